// ---- i2csf_pkg.sv ----
// Package holding constants and types for the I2C status and condition block
package i2csf_pkg;

    //////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] OFS_STATUS = 8'h00; // Status and condition control
    localparam logic [7:0] OFS_CONTROL = 8'h04; // Mode bits
    localparam logic [7:0] OFS_SLAVE_ADDR = 8'h08; // Own address and format
    localparam logic [7:0] OFS_DATA = 8'h0c; // Data register window

    //////////////////////////////////////////////////////////////////////////
    // Status register field positions
    localparam int BIT_BUS_BUSY = 7;
    localparam int BIT_IRQ_REQ = 6;
    localparam int BIT_COND_INHIBIT = 5;
    localparam int BIT_RESERVED = 4;
    localparam int BIT_ARB_LOST = 3;
    localparam int BIT_ADDR_MATCH = 2;
    localparam int BIT_BROADCAST = 1;
    localparam int BIT_ACK = 0;

    // Control register field positions
    localparam int BIT_MASTER = 0;
    localparam int BIT_TRANSMIT = 1;

    // Slave address register field positions
    localparam int BIT_FORMAT = 0;
    localparam int LSB_OWN_ADDR = 1;

    //////////////////////////////////////////////////////////////////////////
    // Reset values and the broadcast address
    localparam logic [7:0] STATUS_RESET = 8'h30; // Read value after reset
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] SLAVE_ADDR_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [7:0] GENERAL_CALL_ADDR = 8'h00; // Broadcast address byte

    //////////////////////////////////////////////////////////////////////////
    // Timing: each phase of a start or stop condition
    localparam int COND_HOLD_NS = 4000; // Least hold per phase
    localparam int CLK_PERIOD_PS = 4000; // 250 MHz
    localparam int COND_CYCLES_INT = (COND_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [11:0] COND_CYCLES = 12'(COND_CYCLES_INT);

    //////////////////////////////////////////////////////////////////////////
    // Condition sequencer states, Gray between successive non-idle states of each path
    typedef enum logic [2:0] {
        COND_IDLE = 3'h0,
        COND_RS_SDA_HI = 3'h1,
        COND_ST_SCL_HI = 3'h3,
        COND_ST_SDA_LO = 3'h2,
        COND_ST_SCL_LO = 3'h6,
        COND_SP_SDA_LO = 3'h7,
        COND_SP_SCL_HI = 3'h5,
        COND_SP_SDA_HI = 3'h4
    } i2csf_cond_type;

    // Bus line levels
    typedef struct packed {
        logic scl;
        logic sda;
    } i2csf_line_type;

    // Events seen on the bus lines
    typedef struct packed {
        logic scl_rise;
        logic scl_fall;
        logic start_seen;
        logic stop_seen;
    } i2csf_edge_type;

endpackage : i2csf_pkg

// ---- i2csf_pin_sync.sv ----
// Synchroniser and edge detector for the SCL and SDA bus lines
`timescale 1ns/1ps
module i2csf_pin_sync
    import i2csf_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire i2csf_line_type line_in,
    output i2csf_line_type line_out,
    output i2csf_edge_type edge_out
);

    // All flops of this module
    typedef struct packed {
        i2csf_line_type s1; // First stage, read only by s2
        i2csf_line_type s2; // Safe level
        i2csf_line_type s3; // Previous safe level
    } i2csf_sync_state_type;

    i2csf_sync_state_type r;
    i2csf_sync_state_type next_r;

    //////////////////////////////////////////////////////////////////////////
    // Shift chain
    always_comb begin
        next_r = r;
        next_r.s1 = line_in;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
    end

    // Lines idle high, so reset to high avoids a false edge
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            r <= '1;
        end else begin
            r <= next_r;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Edges from the second and third stages only
    assign line_out = r.s2;
    assign edge_out.scl_rise = r.s2.scl & ~r.s3.scl;
    assign edge_out.scl_fall = ~r.s2.scl & r.s3.scl;
    // SDA moving while SCL stays high marks start or stop
    assign edge_out.start_seen = r.s2.scl & r.s3.scl & ~r.s2.sda & r.s3.sda;
    assign edge_out.stop_seen = r.s2.scl & r.s3.scl & r.s2.sda & ~r.s3.sda;

endmodule : i2csf_pin_sync

// ---- i2csf_top.sv ----
// Status flags and start/stop issuing for the I2C interface, AHB-Lite slave
//
// Chosen here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
module i2csf_top
    import i2csf_pkg::*;
(
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic HSEL,
    input wire logic [7:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic SCL_I,
    input wire logic SDA_I,
    output logic SCL_O,
    output logic SCL_OE,
    output logic SDA_O,
    output logic SDA_OE,
    input wire logic ENG_SCL_LOW,
    input wire logic ENG_SDA_LOW,
    input wire logic TX_ACTIVE,
    input wire logic ACK_SAMPLE,
    input wire logic ACK_WINDOW,
    input wire logic RX_FIRST_VALID,
    input wire logic [7:0] RX_BYTE,
    output logic [7:0] DATA_TX,
    output logic DATA_WR_STB,
    output logic DATA_RD_STB,
    output logic MASTER_MODE,
    output logic TRANSMIT_SELECT,
    output logic COND_BUSY,
    output logic IRQ_REQ
);

    //////////////////////////////////////////////////////////////////////////
    // All state of the block
    typedef struct packed {
        i2csf_cond_type cond; // Start/stop sequencer
        logic [11:0] cond_cnt; // Cycles left in current phase
        logic scl_pull; // Drive SCL low
        logic sda_pull; // Drive SDA low
        logic bus_busy_flag;
        logic irq_request_flag;
        logic arb_lost_flag;
        logic own_addr_match_flag;
        logic broadcast_hit_flag;
        logic ack_rx; // Acknowledge captured from bus
        logic ack_sw; // Acknowledge set by software
        logic arm_irq; // Flag was read as one
        logic arm_al;
        logic arm_aas;
        logic arm_adz;
        logic master; // Master mode
        logic transmit_select;
        logic format_select; // Zero selects addressing format
        logic [6:0] own_address_bits;
        logic [7:0] data_reg; // Last byte written by software
        logic dph_wr; // Write data phase pending
        logic [7:0] dph_addr; // Address of pending write
        logic [31:0] rdata; // Read data for the data phase
        logic data_wr_stb;
        logic data_rd_stb;
    } i2csf_state_type;

    i2csf_state_type r;
    i2csf_state_type next_r;

    i2csf_line_type line_raw; // Unsynchronised pins
    i2csf_line_type line; // Synchronised bus levels
    i2csf_edge_type edge_ev; // Bus events
    logic addr_ok; // Valid AHB address phase
    logic mt_active; // Shifting as master transmitter
    logic al_event; // Arbitration loss this cycle
    logic gc_hit; // First byte equals broadcast address
    logic match_hit; // First byte addressed to us
    logic slave_rx; // Slave receive with addressing
    logic ack_read; // Ack bit as software reads it
    logic [7:0] status_rd; // Status register read value
    logic [7:0] w; // Write byte of the data phase

    //////////////////////////////////////////////////////////////////////////
    // Bus line synchroniser
    assign line_raw.scl = SCL_I;
    assign line_raw.sda = SDA_I;

    i2csf_pin_sync u_sync (
        .clk(CLK),
        .rstn(RSTN),
        .line_in(line_raw),
        .line_out(line),
        .edge_out(edge_ev)
    );

    //////////////////////////////////////////////////////////////////////////
    // Decoded helpers
    assign addr_ok = HSEL & HREADY & HTRANS[1];
    assign w = HWDATA[7:0];
    assign mt_active = r.master & r.transmit_select & TX_ACTIVE;
    // Driven level differs from the bus at SCL rise
    assign al_event = (mt_active & edge_ev.scl_rise & (r.sda_pull == line.sda))
        // Someone else pulled SCL while ours was released
        | (mt_active & edge_ev.scl_fall & ~r.scl_pull);
    assign slave_rx = ~r.master & ~r.transmit_select & ~r.format_select;
    assign gc_hit = RX_BYTE == GENERAL_CALL_ADDR;
    assign match_hit = (RX_BYTE[7:1] == r.own_address_bits) | gc_hit;
    // Ack read follows the direction
    assign ack_read = r.transmit_select ? r.ack_rx : r.ack_sw;

    // Inhibit and reserved bits read as constant one
    always_comb begin
        status_rd = STATUS_RESET;
        status_rd[BIT_BUS_BUSY] = r.bus_busy_flag;
        status_rd[BIT_IRQ_REQ] = r.irq_request_flag;
        status_rd[BIT_ARB_LOST] = r.arb_lost_flag;
        status_rd[BIT_ADDR_MATCH] = r.own_addr_match_flag;
        status_rd[BIT_BROADCAST] = r.broadcast_hit_flag;
        status_rd[BIT_ACK] = ack_read;
    end

    //////////////////////////////////////////////////////////////////////////
    // Next state: clears first, hardware sets last so a set wins
    always_comb begin
        next_r = r;
        next_r.data_wr_stb = 1'b0;
        next_r.data_rd_stb = 1'b0;
        next_r.dph_wr = 1'b0;

        // Address phase: reads answer next cycle with no wait state
        if (addr_ok) begin
            next_r.dph_wr = HWRITE;
            next_r.dph_addr = HADDR;
            next_r.rdata = 32'h0; // Unmapped reads return zero
            if (!HWRITE) begin
                unique case (HADDR)
                    OFS_STATUS: begin
                        next_r.rdata = {24'h0, status_rd};
                        // Remember which flags were seen set
                        if (r.irq_request_flag) next_r.arm_irq = 1'b1;
                        if (r.arb_lost_flag) next_r.arm_al = 1'b1;
                        if (r.own_addr_match_flag) next_r.arm_aas = 1'b1;
                        if (r.broadcast_hit_flag) next_r.arm_adz = 1'b1;
                    end
                    OFS_CONTROL: begin
                        next_r.rdata[BIT_MASTER] = r.master;
                        next_r.rdata[BIT_TRANSMIT] = r.transmit_select;
                    end
                    OFS_SLAVE_ADDR: begin
                        next_r.rdata[BIT_FORMAT] = r.format_select;
                        next_r.rdata[LSB_OWN_ADDR +: 7] = r.own_address_bits;
                    end
                    OFS_DATA: begin
                        next_r.rdata = {24'h0, RX_BYTE};
                        next_r.data_rd_stb = 1'b1;
                        // Receive-mode read retires the arbitration, match and broadcast flags
                        if (!r.transmit_select) begin
                            next_r.arb_lost_flag = 1'b0;
                            next_r.own_addr_match_flag = 1'b0;
                            next_r.broadcast_hit_flag = 1'b0;
                        end
                    end
                    default: begin
                        next_r.rdata = 32'h0;
                    end
                endcase
            end
        end

        // Data phase of a write
        if (r.dph_wr) begin
            unique case (r.dph_addr)
                OFS_STATUS: begin
                    // Zero clears only an armed flag
                    if (!w[BIT_IRQ_REQ] && r.arm_irq) next_r.irq_request_flag = 1'b0;
                    if (!w[BIT_ARB_LOST] && r.arm_al) begin
                        next_r.arb_lost_flag = 1'b0;
                    end
                    if (!w[BIT_ADDR_MATCH] && r.arm_aas) begin
                        next_r.own_addr_match_flag = 1'b0;
                    end
                    if (!w[BIT_BROADCAST] && r.arm_adz) begin
                        next_r.broadcast_hit_flag = 1'b0;
                    end
                    // Any status write uses up the earlier read
                    next_r.arm_irq = 1'b0;
                    next_r.arm_al = 1'b0;
                    next_r.arm_aas = 1'b0;
                    next_r.arm_adz = 1'b0;
                    next_r.ack_sw = w[BIT_ACK];
                    // Inhibit bit is a strobe only; slave mode ignores busy writes
                    if (r.master && !w[BIT_COND_INHIBIT] && r.cond == COND_IDLE) begin
                        if (w[BIT_BUS_BUSY]) begin
                            // Busy bus means repeated start from SCL low
                            next_r.cond = r.bus_busy_flag ? COND_RS_SDA_HI : COND_ST_SCL_HI;
                        end else begin
                            next_r.cond = COND_SP_SDA_LO;
                        end
                        next_r.cond_cnt = COND_CYCLES;
                    end
                end
                OFS_CONTROL: begin
                    next_r.master = w[BIT_MASTER];
                    next_r.transmit_select = w[BIT_TRANSMIT];
                end
                OFS_SLAVE_ADDR: begin
                    next_r.format_select = w[BIT_FORMAT];
                    next_r.own_address_bits = w[LSB_OWN_ADDR +: 7];
                end
                OFS_DATA: begin
                    next_r.data_reg = w;
                    next_r.data_wr_stb = 1'b1;
                    // Transmit-mode write retires the arbitration, match and broadcast flags
                    if (r.transmit_select) begin
                        next_r.arb_lost_flag = 1'b0;
                        next_r.own_addr_match_flag = 1'b0;
                        next_r.broadcast_hit_flag = 1'b0;
                    end
                end
                default: begin
                    next_r.dph_wr = 1'b0; // Unmapped writes are dropped
                end
            endcase
        end

        // Condition sequencer: each phase lasts COND_CYCLES
        if (r.cond != COND_IDLE) begin
            if (r.cond_cnt > 12'h001) begin
                next_r.cond_cnt = r.cond_cnt - 12'h001;
            end else begin
                next_r.cond_cnt = COND_CYCLES;
                unique case (r.cond)
                    COND_RS_SDA_HI: next_r.cond = COND_ST_SCL_HI;
                    COND_ST_SCL_HI: next_r.cond = COND_ST_SDA_LO;
                    COND_ST_SDA_LO: next_r.cond = COND_ST_SCL_LO;
                    COND_ST_SCL_LO: next_r.cond = COND_IDLE;
                    COND_SP_SDA_LO: next_r.cond = COND_SP_SCL_HI;
                    COND_SP_SCL_HI: next_r.cond = COND_SP_SDA_HI;
                    default: next_r.cond = COND_IDLE;
                endcase
            end
        end

        // Pin drive: sequencer overrides the transfer engine
        unique case (r.cond)
            COND_IDLE: begin
                next_r.scl_pull = ENG_SCL_LOW;
                // Receiver answers with the software ack level
                next_r.sda_pull = ENG_SDA_LOW
                    | (ACK_WINDOW & ~r.transmit_select & ~r.ack_sw);
            end
            COND_RS_SDA_HI: begin
                next_r.scl_pull = 1'b1;
                next_r.sda_pull = 1'b0;
            end
            COND_ST_SCL_HI, COND_SP_SDA_HI: begin
                next_r.scl_pull = 1'b0;
                next_r.sda_pull = 1'b0;
            end
            COND_ST_SDA_LO, COND_SP_SCL_HI: begin
                next_r.scl_pull = 1'b0;
                next_r.sda_pull = 1'b1;
            end
            default: begin
                next_r.scl_pull = 1'b1;
                next_r.sda_pull = 1'b1;
            end
        endcase

        // Acknowledge returned by the receiver
        if (ACK_SAMPLE && r.transmit_select) begin
            next_r.ack_rx = line.sda;
        end

        // Bus busy from observed conditions
        if (edge_ev.stop_seen) next_r.bus_busy_flag = 1'b0;
        if (edge_ev.start_seen) next_r.bus_busy_flag = 1'b1;

        // Hardware sets, placed last so they beat any clear
        if (al_event) begin
            next_r.arb_lost_flag = 1'b1;
            next_r.irq_request_flag = 1'b1;
        end
        if (RX_FIRST_VALID && slave_rx && match_hit) begin
            next_r.own_addr_match_flag = 1'b1;
            next_r.irq_request_flag = 1'b1;
            if (gc_hit) next_r.broadcast_hit_flag = 1'b1;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            r <= '0;
            r.cond <= COND_IDLE;
            r.cond_cnt <= COND_CYCLES;
            r.master <= CONTROL_RESET[BIT_MASTER];
            r.transmit_select <= CONTROL_RESET[BIT_TRANSMIT];
            r.format_select <= SLAVE_ADDR_RESET[BIT_FORMAT];
            r.own_address_bits <= SLAVE_ADDR_RESET[7:1];
            r.data_reg <= DATA_RESET;
            r.ack_sw <= STATUS_RESET[BIT_ACK];
        end else begin
            r <= next_r;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Outputs from flops, constants and the decoded COND_BUSY; open-drain pins only ever drive low
    assign HRDATA = r.rdata;
    assign HREADYOUT = 1'b1; // Never waits
    assign HRESP = 1'b0; // Always OKAY
    assign SCL_O = 1'b0;
    assign SDA_O = 1'b0;
    assign SCL_OE = r.scl_pull;
    assign SDA_OE = r.sda_pull;
    assign DATA_TX = r.data_reg;
    assign DATA_WR_STB = r.data_wr_stb;
    assign DATA_RD_STB = r.data_rd_stb;
    assign MASTER_MODE = r.master;
    assign TRANSMIT_SELECT = r.transmit_select;
    assign COND_BUSY = r.cond != COND_IDLE;
    assign IRQ_REQ = r.irq_request_flag;

endmodule : i2csf_top

// ---- i2csf_sva.sv ----
// Concurrent checks on the ports of the status and condition block
`timescale 1ns/1ps
module i2csf_sva
    import i2csf_pkg::*;
(
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic HSEL,
    input wire logic [7:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic SCL_OE,
    input wire logic SDA_OE,
    input wire logic ENG_SDA_LOW,
    input wire logic ACK_WINDOW,
    input wire logic MASTER_MODE,
    input wire logic TRANSMIT_SELECT,
    input wire logic COND_BUSY
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);
    wire logic take = HSEL && HREADY && HTRANS[1] && HADDR == OFS_STATUS; // Status access
    logic rd_stat; // Status read now in data phase
    logic wr_stat; // Status write now in data phase
    logic ack_sw; // Software ack value, shadows the stored bit
    logic [12:0] busy_cnt; // Cycles since the sequencer started, zero while idle
    logic start_path; // Sequencer took the plain start path
    // Track status data phases; the shadow updates where the register does
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            rd_stat <= 1'b0;
            wr_stat <= 1'b0;
            ack_sw <= 1'b0;
            busy_cnt <= 13'h0;
            start_path <= 1'b0;
        end else begin
            // Saturates so a stuck sequencer never wraps onto a legal length
            if (!COND_BUSY) begin
                busy_cnt <= 13'h0;
            end else if (busy_cnt != 13'h1fff) begin
                busy_cnt <= busy_cnt + 13'h1;
            end
            // Both lines released one cycle in marks a start from idle
            start_path <= COND_BUSY && (start_path || (busy_cnt == 13'h1 && !SCL_OE && !SDA_OE));
            rd_stat <= take && !HWRITE;
            wr_stat <= take && HWRITE;
            if (wr_stat) begin
                ack_sw <= HWDATA[0];
            end
        end
    end
    //////////////////////////////////////////////////////////////////////////
    a_inhibit_reads_one: assert property (rd_stat |-> HRDATA[5])
        else $error("inhibit bit read as zero");
    a_reserved_reads_one: assert property (rd_stat |-> HRDATA[4])
        else $error("reserved bit read as zero");
    a_cond_issue: assert property (wr_stat && !HWDATA[5] && MASTER_MODE && !COND_BUSY
        |-> ##[1:2] COND_BUSY) else $error("condition not issued");
    a_inhibit_no_cond: assert property (wr_stat && HWDATA[5] && !COND_BUSY
        |=> !COND_BUSY [*2]) else $error("condition issued with inhibit set");
    a_slave_no_cond: assert property (wr_stat && !MASTER_MODE && !COND_BUSY
        |=> !COND_BUSY [*2]) else $error("condition issued in slave mode");
    a_start_sda_first: assert property (start_path && busy_cnt == COND_CYCLES_INT + 1
        |-> SDA_OE && !$past(SDA_OE) && !SCL_OE) else $error("start order wrong");
    a_start_scl_high: assert property (start_path && busy_cnt <= COND_CYCLES_INT + 1
        |-> !SCL_OE) else $error("clock pulled during start");
    a_cond_span: assert property ($fell(COND_BUSY)
        |-> busy_cnt == 3 * COND_CYCLES_INT || busy_cnt == 4 * COND_CYCLES_INT)
        else $error("condition length wrong");
    a_ack_drive: assert property (ACK_WINDOW && !TRANSMIT_SELECT && !MASTER_MODE
        && !ENG_SDA_LOW && !COND_BUSY && !wr_stat |=> SDA_OE == !ack_sw)
        else $error("ack level not driven");
    // Main scenarios reached
    c_cond: cover property ($rose(COND_BUSY));
    c_match: cover property (rd_stat && HRDATA[2]);
    c_ack: cover property (ACK_WINDOW && SDA_OE);
endmodule : i2csf_sva

// ---- i2csf_bus_peer.sv ----
// Other party on the bus: open-drain lines with pull-ups
`timescale 1ns/1ps
module i2csf_bus_peer (
    input wire logic scl_oe,
    input wire logic sda_oe,
    input wire logic peer_scl_low,
    input wire logic peer_sda_low,
    output logic scl,
    output logic sda
);
    // Wired-AND: any puller wins, released line goes to the pull-up level
    assign scl = !(scl_oe || peer_scl_low);
    assign sda = !(sda_oe || peer_sda_low);
endmodule : i2csf_bus_peer

// ---- tb_top.sv ----
// Self-checking bench for the status and condition block
`timescale 1ns/1ps
module tb_top;
    import i2csf_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, eng_scl = 1'b0;
    logic eng_sda = 1'b0, tx_act = 1'b0, ack_smp = 1'b0, ack_win = 1'b0;
    logic rx_first = 1'b0, p_scl = 1'b0, p_sda = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [7:0] haddr = 8'h00, rx_byte = 8'h00;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [7:0] data_tx;
    logic hready, hresp, scl, sda, scl_oe, sda_oe, tsel, master, cond_busy, irq;
    int error_cnt = 0;
    int checks = 0;
    always #2 clk = ~clk;
    i2csf_top uut (.CLK(clk), .RSTN(rstn), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
        .HREADYOUT(hready), .HRESP(hresp), .SCL_I(scl), .SDA_I(sda), .SCL_O(), .SCL_OE(scl_oe),
        .SDA_O(), .SDA_OE(sda_oe), .ENG_SCL_LOW(eng_scl), .ENG_SDA_LOW(eng_sda),
        .TX_ACTIVE(tx_act), .ACK_SAMPLE(ack_smp), .ACK_WINDOW(ack_win),
        .RX_FIRST_VALID(rx_first), .RX_BYTE(rx_byte), .DATA_TX(data_tx), .DATA_WR_STB(),
        .DATA_RD_STB(), .MASTER_MODE(master), .TRANSMIT_SELECT(tsel), .COND_BUSY(cond_busy),
        .IRQ_REQ(irq));
    i2csf_bus_peer peer (.scl_oe(scl_oe), .sda_oe(sda_oe), .peer_scl_low(p_scl),
        .peer_sda_low(p_sda), .scl(scl), .sda(sda));
    //////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // One single word transfer; holds each phase until ready is seen
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        @(posedge clk);
        hsel <= 1'b1;
        hwrite <= w;
        haddr <= a;
        htrans <= 2'h2;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        r = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk("read", r & m, e);
    endtask : rd
    // Let synchronised line changes and registered outputs settle
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wt
    task automatic pulse(input logic rx, input logic [7:0] b);
        @(posedge clk);
        rx_byte <= b;
        rx_first <= rx;
        ack_smp <= !rx;
        @(posedge clk);
        rx_first <= 1'b0;
        ack_smp <= 1'b0;
    endtask : pulse
    task automatic give_verdict;
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    //////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (30000) @(posedge clk);
        error_cnt++;
        give_verdict();
    end
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        rd(OFS_STATUS, 32'hff, 32'h30);
        rd(8'h10, 32'hffffffff, 32'h0);
        wr(OFS_STATUS, 32'hdf);
        rd(OFS_STATUS, 32'hff, 32'h31);
        wr(OFS_SLAVE_ADDR, 32'h54);
        pulse(1'b1, 8'h54);
        rd(OFS_STATUS, 32'hff, 32'h75);
        wr(OFS_STATUS, 32'h75);
        wr(OFS_STATUS, 32'h01);
        rd(OFS_STATUS, 32'hff, 32'h75);
        wr(OFS_STATUS, 32'h01);
        rd(OFS_STATUS, 32'hff, 32'h31);
        pulse(1'b1, 8'h00);
        rd(OFS_STATUS, 32'hff, 32'h77);
        rd(OFS_DATA, 32'hff, 32'h00);
        rd(OFS_STATUS, 32'hff, 32'h71);
        // Master transmit: peer stretches the clock under us
        wr(OFS_CONTROL, 32'h03);
        tx_act <= 1'b1;
        p_scl <= 1'b1;
        wt(8);
        chk("irq", irq, 1'b1);
        rd(OFS_STATUS, 32'h08, 32'h08);
        p_scl <= 1'b0;
        wr(OFS_DATA, 32'ha5);
        rd(OFS_STATUS, 32'h08, 32'h00);
        chk("data", data_tx, 8'ha5);
        eng_scl <= 1'b1;
        repeat (6) @(posedge clk);
        p_sda <= 1'b1;
        repeat (6) @(posedge clk);
        eng_scl <= 1'b0;
        wt(8);
        rd(OFS_STATUS, 32'h08, 32'h08);
        wr(OFS_STATUS, 32'h20);
        wt(2);
        chk("cond", cond_busy, 1'b0);
        rd(OFS_STATUS, 32'h48, 32'h00);
        tx_act <= 1'b0;
        pulse(1'b0, 8'h00);
        rd(OFS_STATUS, 32'h01, 32'h00);
        p_sda <= 1'b0;
        wt(6);
        pulse(1'b0, 8'h00);
        rd(OFS_STATUS, 32'h01, 32'h01);
        // Slave receive: stored ack level goes onto the data line
        wr(OFS_CONTROL, 32'h00);
        ack_win <= 1'b1;
        wt(3);
        chk("ack0", sda_oe, 1'b1);
        wr(OFS_STATUS, 32'h21);
        wt(3);
        chk("ack1", sda_oe, 1'b0);
        // Start, repeated start, stop as master
        wr(OFS_CONTROL, 32'h01);
        ack_win <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            wr(OFS_STATUS, (k < 2) ? 32'h80 : 32'h00);
            wt(3);
            for (int i = 0; i < 5000 && cond_busy !== 1'b0; i++) @(posedge clk);
            wt(6);
            rd(OFS_STATUS, 32'h80, (k < 2) ? 32'h80 : 32'h00);
        end
        chk("lines", {30'h0, scl, sda}, 32'h3);
        chk("hresp", hresp, 1'b0);
        give_verdict();
    end
endmodule : tb_top
bind i2csf_top i2csf_sva chk (.CLK, .RSTN, .HSEL, .HADDR, .HTRANS, .HWRITE, .HWDATA, .HREADY,
    .HRDATA, .SCL_OE, .SDA_OE, .ENG_SDA_LOW, .ACK_WINDOW, .MASTER_MODE, .TRANSMIT_SELECT,
    .COND_BUSY);
